/* File: asc_seq.sv */
// Converter sequencer: registers, sampling and conversion control, buffer.
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none

module asc_seq (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [asc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [asc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [asc_pkg::DATA_W-1:0] reg_rdata,
	// CPU power state
	input wire logic cpu_sleep,
	input wire logic cpu_idle,
	input wire logic int_enable,
	output logic wake_req,
	// Clock source and trigger
	input wire logic rc_tick,
	input wire logic ext_trig,
	// Analog front end
	input wire logic [asc_pkg::RES_W-1:0] ana_result,
	output logic [3:0] sh_hold,
	output logic conv_busy,
	output logic conv_done,
	output logic analog_power_en
);

	asc_pkg::asc_main_s s;
	asc_pkg::asc_main_s n;
	logic [asc_pkg::RES_W-1:0] buf_mem [asc_pkg::BUF_DEPTH];
	logic buf_we;
	logic hw_we;
	logic [asc_pkg::BUF_IDX_W-1:0] buf_waddr;
	logic [asc_pkg::RES_W-1:0] buf_wdata;
	logic [asc_pkg::DATA_W-1:0] fmt_word;
	logic [asc_pkg::DATA_W-1:0] w1;
	logic [asc_pkg::DATA_W-1:0] w2;
	logic [asc_pkg::DATA_W-1:0] w3;
	logic halt;
	logic clk_ok;
	logic run;
	logic gen_tick;
	logic tad;
	logic trig;
	logic abort;
	logic [1:0] ch_last;
	logic [3:0] en_mask;

	// ****************************************
	// Conversion clock and read formatting
	// ****************************************
	assign halt = cpu_idle && s.sidl;
	assign clk_ok = !cpu_sleep || s.rc;
	assign run = s.on && clk_ok && !halt && !s.sleep_off;

	asc_tad_gen #(
		.DIV_W(6)
	) u_tad (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.run(run && !s.rc),
		.divider(s.conversion_clock_divider),
		.tick(gen_tick)
	);

	assign tad = s.rc ? (rc_tick && run) : gen_tick;

	// The layout is applied on every read, so stored data follow a change.
	asc_fmt u_fmt (
		.res(buf_mem[reg_addr[asc_pkg::BUF_IDX_W-1:0]]),
		.layout(s.result_layout_select),
		.word(fmt_word)
	);

	always_comb begin
		w1 = '0;
		w1[asc_pkg::C1_ON] = s.on;
		w1[asc_pkg::C1_SIDL] = s.sidl;
		w1[asc_pkg::C1_RESULT_LAYOUT_SELECT +: 2] = s.result_layout_select;
		w1[asc_pkg::C1_TRIGGER_SOURCE_SELECT +: 3] = s.trigger_source_select;
		w1[asc_pkg::C1_SIMULTANEOUS_SAMPLING] = s.simultaneous_sampling;
		w1[asc_pkg::C1_AUTO_SAMPLE_ENABLE] = s.auto_sample_enable;
		w1[asc_pkg::C1_SAMPLE_CONTROL] = s.sample_control;
		w1[asc_pkg::C1_DONE] = s.done;
		w2 = '0;
		w2[asc_pkg::C2_SH_CHANNEL_COUNT +: 2] = s.sh_channel_count;
		w2[asc_pkg::C2_CONVERSIONS_PER_INTERRUPT +: 4] = s.conversions_per_interrupt;
		w3 = '0;
		w3[asc_pkg::C3_AUTO_SAMPLE_TIME +: 5] = s.auto_sample_time;
		w3[asc_pkg::C3_RC] = s.rc;
		w3[asc_pkg::C3_CONVERSION_CLOCK_DIVIDER +: 6] = s.conversion_clock_divider;
	end

	assign ch_last = (s.sh_channel_count == asc_pkg::SH_CHANNEL_COUNT_ONE) ? 2'h0 :
		(s.sh_channel_count == asc_pkg::SH_CHANNEL_COUNT_TWO) ? 2'h1 : 2'h3;
	assign en_mask = (s.sh_channel_count == asc_pkg::SH_CHANNEL_COUNT_ONE) ? 4'h1 :
		(s.sh_channel_count == asc_pkg::SH_CHANNEL_COUNT_TWO) ? 4'h3 : 4'hF;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		n = s;
		n.wake = 1'b0;
		n.conv_done = 1'b0;
		n.rdata = '0;
		hw_we = 1'b0;
		buf_we = 1'b0;
		buf_waddr = s.wr_ptr;
		buf_wdata = ana_result;
		if (reg_wr) begin
			case (reg_addr)
				asc_pkg::CTRL1_ADDR: begin
					n.on = reg_wdata[asc_pkg::C1_ON];
					n.sidl = reg_wdata[asc_pkg::C1_SIDL];
					n.result_layout_select = reg_wdata[asc_pkg::C1_RESULT_LAYOUT_SELECT +: 2];
					n.trigger_source_select = reg_wdata[asc_pkg::C1_TRIGGER_SOURCE_SELECT +: 3];
					n.simultaneous_sampling = reg_wdata[asc_pkg::C1_SIMULTANEOUS_SAMPLING];
					n.auto_sample_enable = reg_wdata[asc_pkg::C1_AUTO_SAMPLE_ENABLE];
					n.sample_control = reg_wdata[asc_pkg::C1_SAMPLE_CONTROL];
					n.done = reg_wdata[asc_pkg::C1_DONE];
				end
				asc_pkg::CTRL2_ADDR: begin
					n.sh_channel_count = reg_wdata[asc_pkg::C2_SH_CHANNEL_COUNT +: 2];
					n.conversions_per_interrupt = reg_wdata[asc_pkg::C2_CONVERSIONS_PER_INTERRUPT +: 4];
				end
				asc_pkg::CTRL3_ADDR: begin
					n.auto_sample_time = reg_wdata[asc_pkg::C3_AUTO_SAMPLE_TIME +: 5];
					n.rc = reg_wdata[asc_pkg::C3_RC];
					n.conversion_clock_divider = reg_wdata[asc_pkg::C3_CONVERSION_CLOCK_DIVIDER +: 6];
				end
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				asc_pkg::CTRL1_ADDR: n.rdata = w1;
				asc_pkg::CTRL2_ADDR: n.rdata = w2;
				asc_pkg::CTRL3_ADDR: n.rdata = w3;
				default: begin
					if (reg_addr[asc_pkg::BUF_SEL_BIT]) begin
						n.rdata = fmt_word;
					end
				end
			endcase
		end
		if (!cpu_sleep) begin
			n.sleep_off = 1'b0;
		end
		case (s.trigger_source_select)
			asc_pkg::TRIG_MANUAL: trig = run && !n.sample_control;
			asc_pkg::TRIG_AUTO: trig = tad &&
				({1'b0, s.tad_cnt} + 6'h01 >= {1'b0, s.auto_sample_time});
			default: trig = run && ext_trig;
		endcase
		// Turning off or a Sleep without the RC clock wins over completion.
		abort = !n.on || (cpu_sleep && !s.rc);
		if (abort) begin
			n.state = asc_pkg::ST_IDLE;
			n.tad_cnt = '0;
			n.ch = '0;
			n.wait_cnt = '0;
		end else begin
			case (s.state)
				asc_pkg::ST_IDLE: begin
					if (run && (s.auto_sample_enable || n.sample_control)) begin
						n.state = asc_pkg::ST_SAMPLE;
						n.sample_control = 1'b1;
						n.tad_cnt = '0;
					end
				end
				asc_pkg::ST_SAMPLE: begin
					if (tad) begin
						n.tad_cnt = s.tad_cnt + 5'h01;
					end
					if (trig) begin
						n.sample_control = 1'b0;
						n.tad_cnt = '0;
						n.wait_cnt = '0;
						n.state = cpu_sleep ? asc_pkg::ST_WAIT :
							asc_pkg::ST_CONV;
					end
				end
				asc_pkg::ST_WAIT: begin
					if (s.wait_cnt == 2'(asc_pkg::INSTR_WAIT_CYC - 1)) begin
						n.state = asc_pkg::ST_CONV;
					end else begin
						n.wait_cnt = s.wait_cnt + 2'h1;
					end
				end
				asc_pkg::ST_CONV: begin
					if (tad) begin
						n.tad_cnt = s.tad_cnt + 5'h01;
						if (s.tad_cnt == 5'(asc_pkg::CONV_TADS - 1)) begin
							n.tad_cnt = '0;
							hw_we = 1'b1;
							n.done = 1'b1;
							n.conv_done = 1'b1;
							n.wr_ptr = (s.wr_ptr == s.conversions_per_interrupt) ? 4'h0 :
								s.wr_ptr + 4'h1;
							if (s.ch != ch_last) begin
								// Next channel; in sequential mode only it is held, simultaneous sampling holds all enabled channels.
								n.ch = s.ch + 2'h1;
							end else begin
								n.ch = '0;
								if (cpu_sleep && int_enable) begin
									n.wake = 1'b1;
								end
								if (cpu_sleep && !int_enable) begin
									n.sleep_off = 1'b1;
								end
								n.sample_control = s.auto_sample_enable &&
									!(cpu_sleep && !int_enable);
								n.state = n.sample_control ? asc_pkg::ST_SAMPLE :
									asc_pkg::ST_IDLE;
							end
						end
					end
				end
				default: n.state = asc_pkg::ST_IDLE;
			endcase
		end
		if (hw_we) begin
			buf_we = 1'b1;
		end else if (reg_wr && reg_addr[asc_pkg::BUF_SEL_BIT]) begin
			buf_we = 1'b1;
			buf_waddr = reg_addr[asc_pkg::BUF_IDX_W-1:0];
			buf_wdata = reg_wdata[asc_pkg::RES_W-1:0];
		end
		n.busy = (n.state == asc_pkg::ST_CONV);
		if (n.state != asc_pkg::ST_CONV) begin
			n.hold = 4'h0;
		end else if (s.simultaneous_sampling) begin
			n.hold = en_mask;
		end else begin
			n.hold = 4'h1 << n.ch;
		end
		n.pwr = n.on && !n.sleep_off;
	end

	// ****************************************
	// Registers and buffer
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s <= asc_pkg::MAIN_RST;
		end else begin
			s <= n;
		end
	end

	// No reset here: stored results survive a device reset.
	always_ff @(posedge core_clk) begin
		if (buf_we) begin
			buf_mem[buf_waddr] <= buf_wdata;
		end
	end

	assign reg_rdata = s.rdata;
	assign wake_req = s.wake;
	assign sh_hold = s.hold;
	assign conv_busy = s.busy;
	assign conv_done = s.conv_done;
	assign analog_power_en = s.pwr;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	off_power_a: assert property (!s.on |-> !s.pwr && !s.busy)
		else $error("module powered while off");
	sleep_abort_a: assert property (cpu_sleep && !s.rc &&
		s.state == asc_pkg::ST_CONV |=> s.state == asc_pkg::ST_IDLE)
		else $error("conversion not aborted in sleep");
	sleep_keep_a: assert property ($rose(cpu_sleep) && !reg_wr
		|=> {s.on, s.result_layout_select, s.trigger_source_select, s.sh_channel_count, s.conversion_clock_divider} ==
		$past({s.on, s.result_layout_select, s.trigger_source_select, s.sh_channel_count, s.conversion_clock_divider}))
		else $error("registers changed on sleep entry");
	rc_delay_a: assert property (s.state == asc_pkg::ST_WAIT &&
		$past(s.state) == asc_pkg::ST_SAMPLE && s.on && !$past(sys_rst)
		|=> (s.state == asc_pkg::ST_WAIT || !s.on) ##1
		(s.state == asc_pkg::ST_CONV || !s.on))
		else $error("rc start delay wrong");
	done_flag_a: assert property (conv_done |-> s.done)
		else $error("done flag not set at completion");
	sleep_wake_a: assert property (conv_done && $past(cpu_sleep) &&
		$past(int_enable) && $past(s.ch) == $past(ch_last) |-> wake_req)
		else $error("no wake after sleep conversion");
	idle_halt_a: assert property (cpu_idle && s.sidl && s.on &&
		!cpu_sleep && !reg_wr |=> $stable(s.tad_cnt))
		else $error("sequencer ran in idle");
	reset_off_a: assert property (disable iff (1'b0)
		sys_rst |=> !s.on && s.state == asc_pkg::ST_IDLE)
		else $error("reset did not stop module");
	signed_fmt_a: assert property (reg_rd &&
		reg_addr[asc_pkg::BUF_SEL_BIT] && s.result_layout_select == asc_pkg::RESULT_LAYOUT_SELECT_SINT
		|=> reg_rdata[15:10] == {6{reg_rdata[9]}})
		else $error("signed integer not extended");
	bus_write_a: assert property (reg_wr && !hw_we &&
		reg_addr[asc_pkg::BUF_SEL_BIT] |=>
		buf_mem[$past(reg_addr[3:0])] == $past(reg_wdata[9:0]))
		else $error("buffer write not right justified");
	conv_len_a: assert property (conv_done |->
		$past(s.tad_cnt) == 5'(asc_pkg::CONV_TADS - 1))
		else $error("conversion length wrong");
	auto_start_a: assert property (s.state == asc_pkg::ST_CONV &&
		$past(s.state) == asc_pkg::ST_SAMPLE &&
		$past(s.trigger_source_select) == asc_pkg::TRIG_AUTO |->
		{1'b0, $past(s.tad_cnt)} + 6'h01 >= {1'b0, $past(s.auto_sample_time)})
		else $error("auto start too early");

endmodule // asc_seq

`default_nettype wire

/* File: asc_pkg.sv */
// Package with constants, state codes and carriers of the converter sequencer.
// Behaviour
// - With two channels on one pin, convert one while the other acquires.
// - Sampling is timed by the software sample bit, by the sequencer, or by the external trigger.
// - Converter on powers the module; off disables digital and analog parts.
// - Sleep without the RC clock stops the module clocks and aborts a conversion for good.
// - Entering or leaving Sleep leaves every register unchanged.
// - With the RC clock, Sleep conversions start one instruction cycle late.
// - Conversion end sets the completion flag and stores the result.
// - Sleep conversion end wakes the CPU if enabled, else powers down.
// - In Idle the module runs when stop-in-idle is 0, halts when 1.
// - Reset restores registers, turns off, aborts, but keeps the result buffer.
// - Results are 10 bits; a 2-bit select picks one of three read formats (codes 2 and 3 alike).
// - Integer, sign-extended integer, or result left-justified into bits 15..6.
// - Bus writes to the result buffer are always right-justified integers.
// - A conversion lasts twelve conversion clocks, of (divider+1) half instruction cycles each, or twelve RC clock ticks when RC is selected.
// - Auto trigger starts conversion after the programmed sample clocks.

package asc_pkg;

	// ****************************************
	// Widths and register map
	// ****************************************
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned RES_W = 10;
	localparam int unsigned BUF_IDX_W = 4;
	localparam int unsigned BUF_DEPTH = 16;
	localparam logic [4:0] CTRL1_ADDR = 5'h00;
	localparam logic [4:0] CTRL2_ADDR = 5'h01;
	localparam logic [4:0] CTRL3_ADDR = 5'h02;
	localparam int unsigned BUF_SEL_BIT = 4;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int unsigned C1_ON = 15;
	localparam int unsigned C1_SIDL = 13;
	localparam int unsigned C1_RESULT_LAYOUT_SELECT = 8;
	localparam int unsigned C1_TRIGGER_SOURCE_SELECT = 5;
	localparam int unsigned C1_SIMULTANEOUS_SAMPLING = 3;
	localparam int unsigned C1_AUTO_SAMPLE_ENABLE = 2;
	localparam int unsigned C1_SAMPLE_CONTROL = 1;
	localparam int unsigned C1_DONE = 0;
	localparam int unsigned C2_SH_CHANNEL_COUNT = 8;
	localparam int unsigned C2_CONVERSIONS_PER_INTERRUPT = 2;
	localparam int unsigned C3_AUTO_SAMPLE_TIME = 8;
	localparam int unsigned C3_RC = 7;
	localparam int unsigned C3_CONVERSION_CLOCK_DIVIDER = 0;

	// ****************************************
	// Codes
	// ****************************************
	localparam logic [2:0] TRIG_MANUAL = 3'h0;
	localparam logic [2:0] TRIG_AUTO = 3'h7;
	localparam logic [1:0] RESULT_LAYOUT_SELECT_INT = 2'h0;
	localparam logic [1:0] RESULT_LAYOUT_SELECT_SINT = 2'h1;
	localparam logic [1:0] RESULT_LAYOUT_SELECT_FRAC = 2'h2;
	localparam logic [1:0] RESULT_LAYOUT_SELECT_SFRAC = 2'h3;
	localparam logic [1:0] SH_CHANNEL_COUNT_ONE = 2'h0;
	localparam logic [1:0] SH_CHANNEL_COUNT_TWO = 2'h1;
	localparam int unsigned FRAC_SHIFT = 6;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS = 10;
	// The core clock runs at twice the instruction rate.
	localparam int unsigned INSTR_PERIOD_NS = 20;
	localparam int unsigned INSTR_WAIT_CYC =
		(INSTR_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CONV_TADS = 12;

	// ****************************************
	// State and carriers
	// ****************************************
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_SAMPLE = 4'h2,
		ST_WAIT = 4'h4,
		ST_CONV = 4'h8
	} asc_state_e;

	typedef struct packed {
		asc_state_e state;
		logic on;
		logic sidl;
		logic [1:0] result_layout_select;
		logic [2:0] trigger_source_select;
		logic simultaneous_sampling;
		logic auto_sample_enable;
		logic sample_control;
		logic done;
		logic [1:0] sh_channel_count;
		logic [3:0] conversions_per_interrupt;
		logic [4:0] auto_sample_time;
		logic rc;
		logic [5:0] conversion_clock_divider;
		logic [4:0] tad_cnt;
		logic [1:0] ch;
		logic [3:0] wr_ptr;
		logic [1:0] wait_cnt;
		logic sleep_off;
		logic wake;
		logic conv_done;
		logic [3:0] hold;
		logic busy;
		logic pwr;
		logic [15:0] rdata;
	} asc_main_s;

	localparam asc_main_s MAIN_RST = '{state: ST_IDLE, default: '0};

endpackage

/* File: asc_tad_gen.sv */
// Conversion clock tick generator dividing the core clock.
`timescale 1ns/10ps
`default_nettype none

module asc_tad_gen #(
	parameter int unsigned DIV_W = 6
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Control
	input wire logic run,
	input wire logic [DIV_W-1:0] divider,
	// Tick
	output logic tick
);

	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic tick;
	} asc_tad_s;

	asc_tad_s s;
	asc_tad_s n;

	// One tick every divider+1 core cycles; the count restarts when halted.
	always_comb begin
		n = s;
		n.tick = 1'b0;
		if (!run) begin
			n.cnt = '0;
		end else if (s.cnt >= divider) begin
			n.cnt = '0;
			n.tick = 1'b1;
		end else begin
			n.cnt = s.cnt + 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign tick = s.tick;

endmodule // asc_tad_gen

`default_nettype wire

/* File: asc_fmt.sv */
// Read formatter of stored 10-bit results onto the 16-bit data bus.
`timescale 1ns/10ps
`default_nettype none

module asc_fmt (
	// Stored value and layout
	input wire logic [asc_pkg::RES_W-1:0] res,
	input wire logic [1:0] layout,
	// Bus word
	output logic [asc_pkg::DATA_W-1:0] word
);

	localparam int unsigned EXT_W = asc_pkg::DATA_W - asc_pkg::RES_W;

	always_comb begin
		case (layout)
			asc_pkg::RESULT_LAYOUT_SELECT_INT: word = {{EXT_W{1'b0}}, res};
			asc_pkg::RESULT_LAYOUT_SELECT_SINT: word = {{EXT_W{res[asc_pkg::RES_W-1]}}, res};
			default: word = {res, {asc_pkg::FRAC_SHIFT{1'b0}}};
		endcase
	end

endmodule // asc_fmt

`default_nettype wire

/* File: asc_afe_model.sv */
// Analog front end model: conversion values and RC clock ticks.
`timescale 1ns/10ps
`default_nettype none

module asc_afe_model (
	// Clock
	input wire logic core_clk,
	// Sequencer side
	input wire logic conv_busy,
	input wire logic conv_done,
	// Analog side
	output logic [9:0] ana_result,
	output logic [9:0] last_val,
	output logic rc_tick
);
	logic [9:0] cur = 10'h2B5;
	logic [4:0] cyc = 5'h00;
	// Outside a conversion nothing is held, so the input keeps moving.
	assign ana_result = conv_busy ? cur : cur ^ {5'h1F, cyc};
	assign rc_tick = (cyc[1:0] == 2'h0);
	always @(posedge core_clk) begin
		cyc <= cyc + 5'h01;
		if (conv_done) begin
			last_val <= cur;
			cur <= cur + 10'h0D3;
		end
	end
endmodule // asc_afe_model
`default_nettype wire

/* File: asc_seq_test.sv */
// Self-checking bench of the converter sequencer.
`timescale 1ns/10ps
`default_nettype none

module asc_seq_test;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [4:0] reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic cpu_sleep = 1'b0;
	logic cpu_idle = 1'b0;
	logic int_enable = 1'b0;
	logic [15:0] reg_rdata;
	logic wake_req;
	logic conv_busy;
	logic conv_done;
	logic analog_power_en;
	logic rc_tick;
	logic [3:0] sh_hold;
	logic [9:0] ana_result;
	logic [9:0] last_val;
	logic [15:0] d;
	int bad_count = 0;
	int checks = 0;
	int cyc = 0;
	int n;
	int w;
	localparam logic [15:0] AUTO = 16'h80E4;

	asc_seq i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_sleep(cpu_sleep),
		.cpu_idle(cpu_idle), .int_enable(int_enable), .wake_req(wake_req),
		.rc_tick(rc_tick), .ext_trig(1'b0), .ana_result(ana_result),
		.sh_hold(sh_hold), .conv_busy(conv_busy), .conv_done(conv_done),
		.analog_power_en(analog_power_en));

	asc_afe_model i_afe (.core_clk(core_clk), .conv_busy(conv_busy),
		.conv_done(conv_done), .ana_result(ana_result),
		.last_val(last_val), .rc_tick(rc_tick));

	initial begin
		forever #5 core_clk = ~core_clk;
	end

	// ****************************************
	// Bus and checking tasks
	// ****************************************
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Counts completion and wake pulses over a fixed window.
	task automatic count_done(input int cycles);
		n = 0;
		w = 0;
		repeat (cycles) begin
			@(posedge core_clk);
			#1;
			if (conv_done === 1'b1) n++;
			if (wake_req === 1'b1) w++;
		end
	endtask

	// Waits a bounded time for the busy level and counts the cycles.
	task automatic wait_busy(input logic v);
		n = 0;
		while (conv_busy !== v && n < 300) begin
			@(posedge core_clk);
			#1;
			n++;
		end
	endtask

	task automatic wait_hold(input logic [3:0] v);
		n = 0;
		while (sh_hold !== v && n < 100) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk(16'(sh_hold), 16'(v));
	endtask

	function automatic logic [15:0] fmt(input logic [9:0] v,
		input logic [1:0] f);
		if (f == 2'h0) return {6'h00, v};
		if (f == 2'h1) return {{6{v[9]}}, v};
		return {v, 6'h00};
	endfunction

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			print_verdict();
		end
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			rd(i == 3 ? 5'h05 : 5'(i));
			chk(d, 16'h0000);
		end
		chk(16'(analog_power_en), 16'h0000);
		$display("End of test: reset values");
		for (int dv = 0; dv < 2; dv++) begin
			// Start each pass stopped, so that a whole conversion is timed.
			wr(5'h00, 16'h0000);
			wr(5'h02, 16'h0100 | 16'(dv));
			rd(5'h02);
			chk(d, 16'h0100 | 16'(dv));
			wr(5'h00, AUTO);
			wait_busy(1'b1);
			chk(16'(analog_power_en), 16'h0001);
			wait_busy(1'b0);
			chk(16'(n >= 12 * (dv + 1) && n <= 12 * (dv + 1) + 2), 16'h0001);
		end
		rd(5'h00);
		// Auto sampling has already restarted, so the sample bit reads set.
		chk(d, AUTO | 16'h0003);
		wr(5'h00, 16'h0000);
		count_done(40);
		chk(16'(n), 16'h0000);
		chk(16'(analog_power_en), 16'h0000);
		$display("End of test: auto conversion");
		wr(5'h11, 16'hFD55);
		for (int f = 0; f < 4; f++) begin
			wr(5'h00, 16'(f) << 8);
			rd(5'h10);
			chk(d, fmt(last_val, 2'(f)));
			rd(5'h11);
			chk(d, fmt(10'h155, 2'(f)));
		end
		$display("End of test: read formats");
		wr(5'h00, AUTO);
		wait_busy(1'b1);
		@(posedge core_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		#1;
		chk(16'(analog_power_en), 16'h0000);
		chk(16'(conv_busy), 16'h0000);
		rd(5'h00);
		chk(d, 16'h0000);
		rd(5'h11);
		chk(d, 16'h0155);
		$display("End of test: reset in conversion");
		wr(5'h02, 16'h0100);
		cpu_idle <= 1'b1;
		wr(5'h00, AUTO | 16'h2000);
		count_done(60);
		chk(16'(n), 16'h0000);
		wr(5'h00, AUTO);
		count_done(60);
		chk(16'(n >= 2), 16'h0001);
		@(posedge core_clk);
		cpu_idle <= 1'b0;
		wr(5'h00, 16'h0002);
		repeat (4) @(posedge core_clk);
		wr(5'h00, 16'h8002);
		repeat (4) @(posedge core_clk);
		wr(5'h00, 16'h8000);
		count_done(40);
		chk(16'(n), 16'h0001);
		$display("End of test: idle and manual sampling");
		wr(5'h00, AUTO);
		wait_busy(1'b1);
		@(posedge core_clk);
		cpu_sleep <= 1'b1;
		count_done(40);
		chk(16'(n), 16'h0000);
		rd(5'h00);
		chk(d & 16'hFFFE, AUTO);
		@(posedge core_clk);
		cpu_sleep <= 1'b0;
		count_done(40);
		chk(16'(n >= 1), 16'h0001);
		wr(5'h00, 16'h0000);
		wr(5'h02, 16'h0180);
		wr(5'h00, AUTO);
		cpu_sleep <= 1'b1;
		count_done(120);
		chk(16'(n >= 1), 16'h0001);
		chk(16'(analog_power_en), 16'h0000);
		rd(5'h00);
		chk(16'(d[15]), 16'h0001);
		@(posedge core_clk);
		cpu_sleep <= 1'b0;
		int_enable <= 1'b1;
		count_done(10);
		@(posedge core_clk);
		cpu_sleep <= 1'b1;
		count_done(120);
		chk(16'(w >= 1), 16'h0001);
		@(posedge core_clk);
		cpu_sleep <= 1'b0;
		int_enable <= 1'b0;
		wr(5'h00, 16'h0000);
		$display("End of test: sleep");
		wr(5'h02, 16'h0200);
		wr(5'h01, 16'h0104);
		wr(5'h00, AUTO);
		wait_hold(4'h1);
		wait_hold(4'h2);
		wr(5'h00, 16'h0000);
		$display("End of test: two channels");
		print_verdict();
	end
endmodule // asc_seq_test
`default_nettype wire
